/* common/seq_params.svh */
// Constants of the measurement trigger sequencer.
// Assumes one 100 MHz clock; times on the ports are in milliseconds, except phase_cycles, in clock cycles.
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

`define SEQ_CLK_PERIOD_NS    10
`define SEQ_TICK_PERIOD_MS   1
`define SEQ_TICK_CYCLES      ((`SEQ_TICK_PERIOD_MS * 1000000) / `SEQ_CLK_PERIOD_NS)

`define SEQ_AVG_W            16
`define SEQ_CNT_W            14
`define SEQ_WAIT_W           13
`define SEQ_DLY_W            15
`define SEQ_PHASE_W          24
`define SEQ_DATA_W           24

`define SEQ_FB_WAIT_RST_MS   13'h012C
`define SEQ_FB_WAIT_MIN_MS   13'h0064
`define SEQ_FB_WAIT_MAX_MS   13'h1388
`define SEQ_TRIG_DLY_RST_MS  15'h0000
`define SEQ_TRIG_CNT_RST     14'h0001
`define SEQ_TRIG_CNT_MAX     14'h2000
`define SEQ_AVG_CNT_RST      16'h0001
`define SEQ_PHASE_RST        24'h000001

`endif

/* common/seq_pkg.sv */
// Types of the measurement trigger sequencer.
// Assumes seq_params.svh is on the include path.
`include "seq_params.svh"

package seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DELAY = 2'b10,
    ST_MEAS  = 2'b11
  } seq_state_type;

  typedef struct packed {
    logic                            continuous;
    logic                            trace_mode;
    logic                            result_output_policy;
    logic                            sync_enable;
    logic                            auto_delay;
    logic [`SEQ_AVG_W-1:0]           avg_count;
    logic [`SEQ_CNT_W-1:0]           trigger_count;
    logic signed [`SEQ_DLY_W-1:0]    trig_delay_ms;
    logic [`SEQ_DLY_W-1:0]           settle_ms;
    logic [`SEQ_PHASE_W-1:0]         phase_cycles;
  } seq_cfg_type;

  typedef struct packed {
    seq_state_type                   state;
    logic                            sync_out;
    logic                            chop_inverted;
    logic                            result_valid;
    logic                            result_settled;
    logic signed [`SEQ_DATA_W-1:0]   result_value;
    logic [`SEQ_CNT_W-1:0]           result_index;
    logic [`SEQ_CNT_W-1:0]           fallback_trigger_tally;
  } seq_status_type;

endpackage

/* rtl/tick_divider.sv */
// Divides the system clock into a one-cycle time-base enable.
// Assumes a single clock and an active-low asynchronous reset.
module tick_divider #(
  parameter int DIV = 100000
) (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      tick
);

  localparam int CW = $clog2(DIV + 1);

  logic [CW-1:0] cnt_reg;
  logic          tick_reg;
  wire           at_end = (cnt_reg == CW'(DIV - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= at_end ? '0 : cnt_reg + 1'b1;
      tick_reg <= at_end;
    end
  end

  assign tick = tick_reg;

endmodule // tick_divider

/* rtl/measurement_trigger_sequencer.sv */
// Trigger sequencer for chopper-stabilised average and trace measurements.
// Assumes inputs synchronous to clk; cfg is taken when started, the fallback inputs are used live.
// Operation
// RULE1: Average mode measurement is two chopper phases, two aperture times.
// RULE2: Full-cycle average mode starts a cycle only on a trigger event.
// RULE3: Full-cycle output gives one result after average count measurements.
// RULE4: Full-cycle sync stays high through the whole averaging cycle.
// RULE5: Sliding output: each measurement needs a trigger and gives a result.
// RULE6: Sliding output: sync high during each measurement, low between.
// RULE7: Sliding results unsettled until average count reached, then settled.
// RULE8: After trigger count measurements the sequencer returns to idle.
// RULE9: Average count one: one aperture time, settled result, then idle.
// RULE10: Trace mode: each phase starts on a trigger, sync high during it.
// RULE11: Trace: two phases per measurement; full output after average count.
// RULE12: Trace sliding: result per measurement, settled after average count.
// RULE13: Trace average count one: one trace time, settled data, then idle.
// RULE14: Single run sequences like continuous but does not restart.
// RULE15: Fallback trigger fires after its wait when enabled and untriggered.
// RULE16: Fallback wait 0.1 to 5.0 s, reset 0.3 s, only when enabled.
// RULE17: Count measurements started by fallback trigger since enabling.
// RULE18: Trigger count 1 to 8192, reset 1; restart internally until done.
// RULE19: Wait programmed trigger delay, -5.0 to 10.0 s, before integrating.
// RULE20: Auto delay waits for settling unless programmed delay is longer.
// RULE21: States idle, waiting for trigger, measuring; trigger starts measuring.
// RULE22: Continuous mode re-enters waiting for trigger after completion.
// RULE23: Noninverted phase first, then inverted; their samples are combined.
`include "seq_params.svh"
module measurement_trigger_sequencer
  import seq_pkg::*;
#(
  parameter int TICK_CYCLES = `SEQ_TICK_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          init_start,
  input  wire logic                          abort,
  input  wire seq_cfg_type                   cfg,
  input  wire logic                          fallback_trigger_enable,
  input  wire logic [`SEQ_WAIT_W-1:0]        fallback_trigger_wait,
  input  wire logic                          trigger_event,
  input  wire logic signed [`SEQ_DATA_W-1:0] phase_sample,
  output seq_status_type                     status
);

  // Time base
  logic tick;

  tick_divider #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (tick)
  );

  // State
  seq_state_type                  state_reg;
  seq_state_type                  state_next;
  seq_cfg_type                    cfg_reg;
  logic                           inv_reg;
  logic [`SEQ_PHASE_W-1:0]        phase_cnt_reg;
  logic [`SEQ_DLY_W-1:0]          ms_cnt_reg;
  logic [`SEQ_AVG_W-1:0]          meas_cycle_reg;
  logic [`SEQ_AVG_W-1:0]          meas_total_reg;
  logic [`SEQ_CNT_W-1:0]          result_cnt_reg;
  logic [`SEQ_CNT_W-1:0]          tally_reg;
  logic                           fb_enable_d_reg;
  logic signed [`SEQ_DATA_W-1:0]  noninv_reg;
  logic signed [`SEQ_DATA_W-1:0]  value_reg;
  logic                           valid_reg;
  logic                           settled_reg;

  function automatic seq_cfg_type reset_cfg();
    seq_cfg_type c;
    c                      = '0;
    c.avg_count            = `SEQ_AVG_CNT_RST;
    c.trigger_count        = `SEQ_TRIG_CNT_RST;
    c.trig_delay_ms        = `SEQ_TRIG_DLY_RST_MS;
    c.phase_cycles         = `SEQ_PHASE_RST;
    return c;
  endfunction

  function automatic logic [`SEQ_CNT_W-1:0] clamp_count(
    input logic [`SEQ_CNT_W-1:0] n
  );
    logic [`SEQ_CNT_W-1:0] r;
    r = n;
    if (n == '0) begin
      r = `SEQ_TRIG_CNT_RST;
    end else if (n > `SEQ_TRIG_CNT_MAX) begin
      r = `SEQ_TRIG_CNT_MAX;
    end
    return r;
  endfunction

  // Fallback wait held inside its range
  wire [`SEQ_WAIT_W-1:0] fb_wait =                         // RULE16
    (fallback_trigger_wait < `SEQ_FB_WAIT_MIN_MS) ? `SEQ_FB_WAIT_MIN_MS :
    (fallback_trigger_wait > `SEQ_FB_WAIT_MAX_MS) ? `SEQ_FB_WAIT_MAX_MS :
    fallback_trigger_wait;

  // Negative delay means pre-trigger data; the programmed wait is zero then
  wire [`SEQ_DLY_W-1:0] prog_dly = cfg_reg.trig_delay_ms[`SEQ_DLY_W-1] ?
                                   '0 : cfg_reg.trig_delay_ms;   // RULE19
  wire [`SEQ_DLY_W-1:0] auto_dly = cfg_reg.auto_delay ?
                                   cfg_reg.settle_ms : '0;
  wire [`SEQ_DLY_W-1:0] eff_dly  = (auto_dly > prog_dly) ?
                                   auto_dly : prog_dly;          // RULE20

  // Decoding
  wire avg_one    = (cfg_reg.avg_count <= `SEQ_AVG_CNT_RST);  // RULE9 RULE13
  wire sliding    = cfg_reg.result_output_policy;
  wire fb_fire    = fallback_trigger_enable && !trigger_event &&
                    (ms_cnt_reg >= `SEQ_DLY_W'(fb_wait));     // RULE15
  wire trig_take  = (state_reg == ST_WAIT) &&
                    (trigger_event || fb_fire);               // RULE21
  wire dly_zero   = (eff_dly == '0);
  wire dly_done   = (state_reg == ST_DELAY) &&
                    (ms_cnt_reg >= eff_dly);
  wire phase_end  = (state_reg == ST_MEAS) &&
                    (phase_cnt_reg >= cfg_reg.phase_cycles - 1'b1);
  wire meas_end   = phase_end && (inv_reg || avg_one);        // RULE1
  wire [`SEQ_AVG_W-1:0] cycle_inc = meas_cycle_reg + 1'b1;
  wire [`SEQ_AVG_W-1:0] total_inc = (meas_total_reg == '1) ?
                                    meas_total_reg : meas_total_reg + 1'b1;
  wire result_due = meas_end && (avg_one || sliding ||
                    (cycle_inc >= cfg_reg.avg_count));        // RULE3 RULE11
  wire [`SEQ_CNT_W-1:0] result_inc = result_cnt_reg + 1'b1;
  wire count_done = avg_one ||
                    (result_inc >= clamp_count(cfg_reg.trigger_count)); // RULE8
  wire restart    = cfg_reg.continuous && !avg_one;           // RULE22 RULE14
  wire settled    = avg_one || !sliding ||
                    (total_inc >= cfg_reg.avg_count);         // RULE7 RULE12
  wire fb_rise    = fallback_trigger_enable && !fb_enable_d_reg;
  wire fb_start   = trig_take && !trigger_event && !inv_reg;  // RULE17
  wire state_move = (state_next != state_reg);

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (init_start) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trig_take) begin
          state_next = dly_zero ? ST_MEAS : ST_DELAY;         // RULE19
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          state_next = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (phase_end) begin
          if (!meas_end) begin
            // Trace mode needs a fresh trigger for the inverted phase
            state_next = cfg_reg.trace_mode ? ST_WAIT : ST_MEAS; // RULE10
          end else if (!result_due) begin
            // Full-cycle average runs on without a trigger; trace waits
            state_next = cfg_reg.trace_mode ? ST_WAIT : ST_MEAS; // RULE2 RULE4
          end else if (!count_done) begin
            state_next = ST_WAIT;                             // RULE18 RULE5
          end else begin
            state_next = restart ? ST_WAIT : ST_IDLE;         // RULE8 RULE22
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end
  end

  // Sequencer state and settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cfg_reg   <= reset_cfg();
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && init_start) begin
        cfg_reg <= cfg;
      end
    end
  end

  // Phase timer and chopper polarity
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_cnt_reg <= '0;
      inv_reg       <= 1'b0;
    end else begin
      if (state_reg != ST_MEAS || phase_end) begin
        phase_cnt_reg <= '0;
      end else begin
        phase_cnt_reg <= phase_cnt_reg + 1'b1;
      end
      if (state_reg == ST_IDLE || meas_end) begin
        inv_reg <= 1'b0;                                      // RULE23
      end else if (phase_end) begin
        inv_reg <= 1'b1;                                      // RULE23
      end
    end
  end

  // Millisecond counter for fallback wait and trigger delay
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_reg <= '0;
    end else if (state_move || state_reg == ST_IDLE ||
                 state_reg == ST_MEAS) begin
      ms_cnt_reg <= '0;
    end else if (tick && ms_cnt_reg != '1) begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;                        // RULE15
    end
  end

  // Measurement and result counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meas_cycle_reg <= '0;
      meas_total_reg <= '0;
      result_cnt_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      meas_cycle_reg <= '0;
      meas_total_reg <= '0;
      result_cnt_reg <= '0;
    end else if (meas_end) begin
      meas_total_reg <= total_inc;                            // RULE7
      meas_cycle_reg <= result_due ? '0 : cycle_inc;          // RULE3
      if (result_due) begin
        result_cnt_reg <= (count_done && restart) ? '0 : result_inc; // RULE18
      end
    end
  end

  // Fallback tally, cleared when the fallback is switched on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tally_reg       <= '0;
      fb_enable_d_reg <= 1'b0;
    end else begin
      fb_enable_d_reg <= fallback_trigger_enable;
      if (fb_rise) begin
        // A fallback start in the enabling cycle still counts
        tally_reg <= {{(`SEQ_CNT_W-1){1'b0}}, fb_start};      // RULE17
      end else if (fb_start && tally_reg != '1) begin
        tally_reg <= tally_reg + 1'b1;                        // RULE17
      end
    end
  end

  // Phase combination and result output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      noninv_reg  <= '0;
      value_reg   <= '0;
      valid_reg   <= 1'b0;
      settled_reg <= 1'b0;
    end else begin
      valid_reg <= result_due && !abort;                      // RULE5 RULE12
      if (phase_end && !inv_reg) begin
        noninv_reg <= phase_sample;
      end
      if (meas_end) begin
        value_reg <= avg_one ? phase_sample :
                     (noninv_reg - phase_sample) >>> 1;       // RULE23
      end
      if (result_due) begin
        settled_reg <= settled;                               // RULE7 RULE9
      end
    end
  end

  // Sync high only while measuring: per phase, per measurement or per cycle
  wire sync_now = cfg_reg.sync_enable &&
                  (state_reg == ST_MEAS);          // RULE4 RULE6 RULE10

  always_comb begin
    status                        = '0;
    status.state                  = state_reg;
    status.sync_out               = sync_now;
    status.chop_inverted          = inv_reg;
    status.result_valid           = valid_reg;
    status.result_settled         = settled_reg;
    status.result_value           = value_reg;
    status.result_index           = result_cnt_reg;
    status.fallback_trigger_tally = tally_reg;
  end

endmodule // measurement_trigger_sequencer

/* sim/seq_checker_assertions.sv */
// Port checker for the measurement trigger sequencer.
// Assumes the bench holds cfg steady while a run is active.
`include "seq_params.svh"
module seq_checker
  import seq_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          arst_n,
  input wire logic                          init_start,
  input wire logic                          abort,
  input wire seq_cfg_type                   cfg,
  input wire logic                          fallback_trigger_enable,
  input wire logic [`SEQ_WAIT_W-1:0]        fallback_trigger_wait,
  input wire logic                          trigger_event,
  input wire logic signed [`SEQ_DATA_W-1:0] phase_sample,
  input wire seq_status_type                status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_start_wait: assert property (
    status.state == ST_IDLE && init_start && !abort
    |=> status.state == ST_WAIT) else $error("start not taken");
  chk_trig_meas: assert property (
    status.state == ST_WAIT && trigger_event && !abort && !cfg.auto_delay
    && cfg.trig_delay_ms <= 0 |=> status.state == ST_MEAS)
    else $error("trigger did not start measuring");
  chk_sync_meas: assert property (
    status.sync_out == (status.state == ST_MEAS && cfg.sync_enable))
    else $error("sync output wrong");
  chk_valid_pulse: assert property (
    status.result_valid |=> !status.result_valid)
    else $error("result valid too long");
  chk_chop_order: assert property (
    $rose(status.state == ST_MEAS) && !cfg.trace_mode
    && cfg.avg_count > 1 && cfg.phase_cycles == 3
    |-> !status.chop_inverted [*3] ##1 status.chop_inverted)
    else $error("chopper phase order wrong");
  chk_avg_one: assert property (
    status.result_valid && cfg.avg_count == 1
    |-> status.state == ST_IDLE && status.result_settled)
    else $error("single phase run not idle");
  chk_full_settled: assert property (
    status.result_valid && !cfg.result_output_policy
    |-> status.result_settled) else $error("full result unsettled");
  chk_tally_clear: assert property (
    $rose(fallback_trigger_enable) && status.state != ST_WAIT
    |-> ##[1:2] status.fallback_trigger_tally == 0)
    else $error("tally not cleared");
  chk_trace_wait: assert property (
    $fell(status.state == ST_MEAS) && cfg.trace_mode && !$past(abort)
    |-> status.state inside {ST_WAIT, ST_IDLE})
    else $error("trace phase did not end in wait");
  cover property (status.result_valid && status.result_settled);
  cover property (status.state == ST_DELAY);
  cover property ($rose(status.chop_inverted));
endmodule // seq_checker

bind measurement_trigger_sequencer seq_checker i_seq_checker (
  .clk(clk), .arst_n(arst_n), .init_start(init_start), .abort(abort),
  .cfg(cfg), .fallback_trigger_enable(fallback_trigger_enable),
  .fallback_trigger_wait(fallback_trigger_wait),
  .trigger_event(trigger_event), .phase_sample(phase_sample),
  .status(status));

/* sim/trig_source.sv */
// Trigger source and detector sample model.
// Assumes pulses are requested by the bench between falling edges.
`include "seq_params.svh"
module trig_source (
  input  wire logic                     clk,
  input  wire logic                     chop_inverted,
  output logic                          trigger_event,
  output logic signed [`SEQ_DATA_W-1:0] phase_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic signed [`SEQ_DATA_W-1:0] AMP = 24'h000123;
  initial trigger_event = 1'b0;
  // Sample sign follows chopper phase
  assign phase_sample = chop_inverted ? -AMP : AMP;
  task automatic pulse();
    @(negedge clk);
    trigger_event = 1'b1;
    @(negedge clk);
    trigger_event = 1'b0;
  endtask
endmodule // trig_source

/* sim/measurement_trigger_sequencer_tb_top.sv */
// Self-checking bench for the measurement trigger sequencer.
// Assumes a 4-cycle millisecond tick and three-cycle chopper phases.
`include "seq_params.svh"
module measurement_trigger_sequencer_tb_top
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          clk = 1'b0;
  logic                          arst_n = 1'b0;
  logic                          init_start = 1'b0;
  logic                          abort = 1'b0;
  logic                          fallback_trigger_enable = 1'b0;
  logic [`SEQ_WAIT_W-1:0]        fallback_trigger_wait = 13'h012C;
  seq_cfg_type                   cfg = '0;
  logic                          trigger_event;
  logic signed [`SEQ_DATA_W-1:0] phase_sample;
  seq_status_type                status;
  int                            bad_count = 0;
  int                            compares = 0;
  int                            res_n = 0;
  int                            cycles = 0;
  int                            cyc;

  measurement_trigger_sequencer #(.TICK_CYCLES(4))
    i_measurement_trigger_sequencer (
    .clk(clk), .arst_n(arst_n), .init_start(init_start), .abort(abort),
    .cfg(cfg), .fallback_trigger_enable(fallback_trigger_enable),
    .fallback_trigger_wait(fallback_trigger_wait),
    .trigger_event(trigger_event), .phase_sample(phase_sample),
    .status(status));
  trig_source i_trig_source (
    .clk(clk), .chop_inverted(status.chop_inverted),
    .trigger_event(trigger_event), .phase_sample(phase_sample));

  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (status.result_valid === 1'b1) res_n <= res_n + 1;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic go(input logic c, t, p, input int avg, cnt, dly,
                    input logic ad);
    @(negedge clk);
    cfg.continuous = c;
    cfg.trace_mode = t;
    cfg.result_output_policy = p;
    cfg.avg_count = avg[15:0];
    cfg.trigger_count = cnt[13:0];
    cfg.trig_delay_ms = dly[14:0];
    cfg.auto_delay = ad;
    init_start = 1'b1;
    @(negedge clk);
    init_start = 1'b0;
  endtask

  task automatic trig();
    int n;
    for (n = 0; n < 3000 && status.state !== ST_WAIT; n++) @(negedge clk);
    i_trig_source.pulse();
  endtask

  task automatic wait_res(input logic st);
    int n;
    for (n = 0; n < 3000 && status.result_valid !== 1'b1; n++) begin
      @(negedge clk);
    end
    cyc = n;
    check(status.result_valid, 1'b1);
    check(status.result_value, 32'h00000123);
    check(status.result_settled, st);
  endtask

  initial begin
    int i;
    cfg.sync_enable = 1'b1;
    cfg.settle_ms = 15'h0003;
    cfg.phase_cycles = 24'h000003;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    check(status.state, ST_IDLE);
    check(status.fallback_trigger_tally, 32'h0);
    go(1'b0, 1'b0, 1'b0, 4, 1, 0, 1'b0);
    trig();
    wait_res(1'b1);
    check(cyc >= 22, 1'b1);
    check(status.state, ST_IDLE);
    repeat (20) @(negedge clk);
    check(res_n, 1);
    $display("full-cycle average done");
    go(1'b0, 1'b0, 1'b1, 2, 3, 0, 1'b0);
    for (i = 0; i < 3; i++) begin
      trig();
      wait_res(i > 0);
      check(status.state, i < 2 ? ST_WAIT : ST_IDLE);
      check(status.result_index, i + 1);
    end
    $display("sliding average done");
    go(1'b1, 1'b0, 1'b1, 1, 1, 5, 1'b0);
    trig();
    check(status.state, ST_DELAY);
    wait_res(1'b1);
    check(cyc >= 16, 1'b1);
    check(status.state, ST_IDLE);
    $display("single phase average done");
    go(1'b1, 1'b1, 1'b0, 2, 1, 0, 1'b0);
    for (i = 0; i < 4; i++) begin
      trig();
      if (i < 3) begin
        repeat (4) @(negedge clk);
        check(status.state, ST_WAIT);
        check(res_n, 5);
      end
    end
    wait_res(1'b1);
    repeat (2) @(negedge clk);
    check(status.state, ST_WAIT);
    check(status.result_index, 32'h0);
    abort = 1'b1;
    @(negedge clk);
    abort = 1'b0;
    check(status.state, ST_IDLE);
    $display("trace full-cycle done");
    go(1'b0, 1'b1, 1'b1, 1, 1, 0, 1'b1);
    trig();
    check(status.state, ST_DELAY);
    wait_res(1'b1);
    check(status.state, ST_IDLE);
    $display("trace single phase done");
    fallback_trigger_wait = 13'h0000;
    fallback_trigger_enable = 1'b1;
    repeat (3) @(negedge clk);
    check(status.fallback_trigger_tally, 32'h0);
    go(1'b0, 1'b0, 1'b0, 1, 1, 0, 1'b0);
    wait_res(1'b1);
    check(cyc >= 380, 1'b1);
    check(status.fallback_trigger_tally, 32'h1);
    $display("fallback trigger done");
    tally_and_finish();
  end
endmodule // measurement_trigger_sequencer_tb_top
